// ==== muldiv_pkg.sv ====
// Purpose: constants shared by the multiply/divide/accumulate coprocessor
// Assumes: 16-bit core data path, 7-bit mode word
// Notes:   operation codes and output selections as decoded by the coprocessor
package muldiv_pkg;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned RES_W    = 32;
  localparam int unsigned MODE_W   = 7;
  localparam int unsigned OP_LSB   = 0;
  localparam int unsigned OP_MSB   = 3;
  localparam int unsigned OUT_LSB  = 4;
  localparam int unsigned OUT_MSB  = 6;
  localparam logic [MODE_W-1:0] MODE_RESET = 7'h00;
  // operation field codes
  localparam logic [3:0] OP_INIT0  = 4'h0;
  localparam logic [3:0] OP_INIT1  = 4'h1;
  localparam logic [3:0] OP_INIT2  = 4'h2;
  localparam logic [3:0] OP_READ   = 4'h3;
  localparam logic [3:0] OP_MULU   = 4'h4;
  localparam logic [3:0] OP_MULS   = 4'h5;
  localparam logic [3:0] OP_MACU   = 4'h6;
  localparam logic [3:0] OP_MACS   = 4'h7;
  localparam logic [3:0] OP_DIVU   = 4'h8;
  localparam logic [3:0] OP_DIVS   = 4'h9;
  localparam logic [3:0] OP_INIT3  = 4'hA;
  // output field codes
  localparam logic [2:0] OUT_R0_LO = 3'h0;
  localparam logic [2:0] OUT_R0_HI = 3'h1;
  localparam logic [2:0] OUT_R1_LO = 3'h2;
  localparam logic [2:0] OUT_R1_HI = 3'h3;
  // flags ordered carry, overflow, zero, negative
  localparam logic [3:0] FLAGS_CLEAR = 4'h0;
  localparam logic [3:0] FLAGS_OVF   = 4'h4;
  // divider timing: cycles of the shift/subtract loop plus the fixup cycle
  localparam int unsigned DIV_STEPS  = 17;
  localparam logic [4:0]  DIV_CNT_W0 = 5'h00;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_DIV  = 3'b010,
    ST_FIX  = 3'b100
  } div_state_t;
endpackage : muldiv_pkg

// ==== muldiv_coprocessor.sv ====
// Function
// - core writes a 7-bit mode word; it stays until the next mode write
// - register-source mode write takes source bits 6..0, ignores destination
// - mode bits 6..4 pick result half returned; codes 4..7 reserved
// - operation code 0 clears both result registers at the mode write
// - code 1 preload puts 16-bit value in result 0 low, zeroes high
// - code 2 preload loads 32 bits to result 0; code A to result 1
// - code 3 transfer returns selected half and changes nothing
// - codes 4 and 5 multiply two 16-bit operands into result 0
// - multiply transfer returns the half of the new product selected
// - multiply and accumulate finish in the transfer's own cycle
// - codes 6 and 7 add the 16x16 product into result 0; code 7 checks overflow
// - codes 8 and 9 divide 32 by 32 in 17 to 20 cycles
// - no zero-divisor or quotient-overflow handling; core avoids such operands
// - result 0 holds a product until later operation overwrites it
// - multiply returns flags all clear with its result half
// - division uses result 0 as dividend; quotient to 0, remainder to 1, flags clear
// - signed division remainder-low output returns an undefined value
// - only signed accumulate flags overflow as 0b0100; unsigned never does
// - each accumulate transfer adds its product; transfers may repeat freely
//
// Purpose: multiply, multiply-accumulate and divide coprocessor for a 16-bit core
// Assumes: transfer strobes are single-cycle and synchronous to i_sys_clk
// Notes:   o_busy stalls the core; o_result and o_flags are valid while o_done is high
`timescale 1ns/1ns
`default_nettype none
module muldiv_coprocessor
  import muldiv_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_mode_write_transfer,
  input  wire logic              i_operand_transfer,
  input  wire logic              i_preload_transfer,
  input  wire logic [DATA_W-1:0] i_dest_operand,
  input  wire logic [DATA_W-1:0] i_src_operand,
  output logic                   o_busy,
  output logic                   o_done,
  output logic      [DATA_W-1:0] o_result,
  output logic      [3:0]        o_flags
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic [MODE_W-1:0] mode_q, mode_d;
  logic [RES_W-1:0]  result_reg_zero_q, result_reg_zero_d;
  logic [RES_W-1:0]  result_reg_one_q, result_reg_one_d;
  logic [DATA_W-1:0] result_q, result_d;
  logic [3:0]        flags_q, flags_d;
  logic              done_q, done_d;
  div_state_t        state_q, state_d;
  // divider working registers: step count, shifting quotient and partial remainder
  logic [4:0]        cnt_q, cnt_d;
  logic [RES_W-1:0]  quo_q, quo_d;
  logic [RES_W:0]    rem_q, rem_d;
  logic [RES_W-1:0]  dvs_q, dvs_d;
  logic              neg_q_q, neg_q_d;
  logic              neg_r_q, neg_r_d;

  logic [3:0]          op;
  logic [2:0]          outsel;
  logic [RES_W-1:0]    src32;
  logic [RES_W-1:0]    prod;
  logic [RES_W-1:0]    mac_sum;
  logic                mac_ovf;
  logic                is_signed;
  logic [RES_W-1:0]    dvd_abs;
  logic [RES_W-1:0]    dvs_abs;
  logic [RES_W:0]      trial;
  logic [RES_W-1:0]    mul_a;
  logic [RES_W-1:0]    mul_b;
  logic [RES_W:0]      rem_mid;
  logic [RES_W-1:0]    quo_mid;
  logic [RES_W:0]      trial2;

  assign op     = mode_q[OP_MSB:OP_LSB];
  assign outsel = mode_q[OUT_MSB:OUT_LSB];
  assign src32  = {i_dest_operand, i_src_operand};

  // ==========================================================================
  // arithmetic
  // ==========================================================================
  // signed and unsigned products share one multiplier; sign picked by decoding op codes 5, 7 and 9
  always_comb
  begin
    is_signed = (op == OP_MULS) || (op == OP_MACS) || (op == OP_DIVS);
    // operands widened first so the product is sized at 32 bits, never at 16
    mul_a   = {{DATA_W{is_signed & i_dest_operand[DATA_W-1]}}, i_dest_operand};
    mul_b   = {{DATA_W{is_signed & i_src_operand[DATA_W-1]}}, i_src_operand};
    prod    = mul_a * mul_b;                          // low 32 bits fit either sign
    mac_sum = prod + result_reg_zero_q;
    // overflow when both addends share a sign the sum lacks
    mac_ovf = (op == OP_MACS) && (prod[RES_W-1] == result_reg_zero_q[RES_W-1])
              && (mac_sum[RES_W-1] != prod[RES_W-1]);
    dvd_abs = (is_signed && result_reg_zero_q[RES_W-1]) ? (~result_reg_zero_q + 32'h0000_0001) : result_reg_zero_q;
    dvs_abs = (is_signed && src32[RES_W-1]) ? (~src32 + 32'h0000_0001) : src32;
    // first of the two restoring steps taken in each divider cycle
    trial   = {rem_q[RES_W-1:0], quo_q[RES_W-1]} - {1'b0, dvs_q};
    if (!trial[RES_W])
    begin
      // shifted remainder covers the divisor: keep the difference, quotient bit 1
      rem_mid = trial;
      quo_mid = {quo_q[RES_W-2:0], 1'b1};
    end
    else
    begin
      // borrow: restore the shifted remainder, quotient bit 0
      rem_mid = {rem_q[RES_W-1:0], quo_q[RES_W-1]};
      quo_mid = {quo_q[RES_W-2:0], 1'b0};
    end
    // second step works on the first one's result within the same cycle
    trial2  = {rem_mid[RES_W-1:0], quo_mid[RES_W-1]} - {1'b0, dvs_q};
  end

  // selected half of a result pair, used for every returned value
  // reserved output codes fall back to result 0 low rather than returning junk
  function automatic logic [DATA_W-1:0] pick
  (
    input logic [2:0]       sel,
    input logic [RES_W-1:0] r0,
    input logic [RES_W-1:0] r1
  );
    logic [DATA_W-1:0] v;
    v = r0[DATA_W-1:0];
    unique case (sel)
      OUT_R0_LO: v = r0[DATA_W-1:0];
      OUT_R0_HI: v = r0[RES_W-1:DATA_W];
      OUT_R1_LO: v = r1[DATA_W-1:0];
      OUT_R1_HI: v = r1[RES_W-1:DATA_W];
      default:   v = r0[DATA_W-1:0];  // reserved output codes read result 0 low
    endcase
    return v;
  endfunction : pick

  // ==========================================================================
  // next-state logic
  // ==========================================================================
  // one process owns mode, results and divider so a transfer's effects stay atomic
  always_comb
  begin
    mode_d   = mode_q;
    result_reg_zero_d   = result_reg_zero_q;
    result_reg_one_d   = result_reg_one_q;
    result_d = result_q;
    flags_d  = flags_q;
    done_d   = 1'b0;
    state_d  = state_q;
    cnt_d    = cnt_q;
    quo_d    = quo_q;
    rem_d    = rem_q;
    dvs_d    = dvs_q;
    neg_q_d  = neg_q_q;
    neg_r_d  = neg_r_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (i_mode_write_transfer)
        begin
          mode_d = i_src_operand[MODE_W-1:0];
          // clearing happens at the mode write itself; no operand follows it
          if (i_src_operand[OP_MSB:OP_LSB] == OP_INIT0)
          begin
            result_reg_zero_d = '0;
            result_reg_one_d = '0;
          end
        end
        else if (i_preload_transfer)
        begin
          // reserved preload codes fall through and change nothing
          if (op == OP_INIT1)
            result_reg_zero_d = {{DATA_W{1'b0}}, i_src_operand};
          else if (op == OP_INIT2)
            result_reg_zero_d = src32;
          else if (op == OP_INIT3)
            result_reg_one_d = src32;
        end
        else if (i_operand_transfer)
        begin
          done_d = 1'b1;
          unique case (op)
            OP_MULU, OP_MULS:
            begin
              result_reg_zero_d   = prod;
              result_d = pick(outsel, prod, result_reg_one_q);
              flags_d  = FLAGS_CLEAR;
            end
            // accumulate keeps adding into result 0 for as long as the mode stays
            OP_MACU, OP_MACS:
            begin
              result_reg_zero_d   = mac_sum;
              result_d = pick(outsel, mac_sum, result_reg_one_q);
              flags_d  = mac_ovf ? FLAGS_OVF : FLAGS_CLEAR;
            end
            OP_DIVU, OP_DIVS:
            begin
              // divisor zero or overflowing quotient gives whatever falls out
              done_d  = 1'b0;
              state_d = ST_DIV;
              cnt_d   = DIV_CNT_W0;
              quo_d   = dvd_abs;
              rem_d   = '0;
              dvs_d   = dvs_abs;
              neg_q_d = is_signed && (result_reg_zero_q[RES_W-1] ^ src32[RES_W-1]);
              neg_r_d = is_signed && result_reg_zero_q[RES_W-1];
            end
            default:
            begin
              // read mode and reserved op codes only return a half
              result_d = pick(outsel, result_reg_zero_q, result_reg_one_q);
            end
          endcase
        end
      end
      ST_DIV:
      begin
        // two quotient bits a cycle: 16 cycles of steps keep the total in range
        if (!trial2[RES_W])
        begin
          rem_d = trial2;
          quo_d = {quo_mid[RES_W-2:0], 1'b1};
        end
        else
        begin
          rem_d = {rem_mid[RES_W-1:0], quo_mid[RES_W-1]};
          quo_d = {quo_mid[RES_W-2:0], 1'b0};
        end
        // the last step cycle counts DIV_STEPS - 2; the fixup cycle makes up the rest
        if (cnt_q == 5'(DIV_STEPS - 2))
          state_d = ST_FIX;
        cnt_d = cnt_q + 5'h01;
      end
      ST_FIX:
      begin
        // quotient negative when operand signs differ; remainder follows dividend
        result_reg_zero_d   = neg_q_q ? (~quo_q + 32'h0000_0001) : quo_q;
        result_reg_one_d   = neg_r_q ? (~rem_q[RES_W-1:0] + 32'h0000_0001) : rem_q[RES_W-1:0];
        // signed remainder-low output is undefined; it returns the computed value
        result_d = pick(outsel, result_reg_zero_d, result_reg_one_d);
        flags_d  = FLAGS_CLEAR;
        done_d   = 1'b1;
        state_d  = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  // synchronous reset; every register loads its next value on every edge
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      mode_q   <= MODE_RESET;
      result_reg_zero_q   <= '0;
      result_reg_one_q   <= '0;
      result_q <= '0;
      flags_q  <= FLAGS_CLEAR;
      done_q   <= 1'b0;
      state_q  <= ST_IDLE;
      cnt_q    <= DIV_CNT_W0;
      quo_q    <= '0;
      rem_q    <= '0;
      dvs_q    <= '0;
      neg_q_q  <= 1'b0;
      neg_r_q  <= 1'b0;
    end
    else
    begin
      mode_q   <= mode_d;
      result_reg_zero_q   <= result_reg_zero_d;
      result_reg_one_q   <= result_reg_one_d;
      result_q <= result_d;
      flags_q  <= flags_d;
      done_q   <= done_d;
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      quo_q    <= quo_d;
      rem_q    <= rem_d;
      dvs_q    <= dvs_d;
      neg_q_q  <= neg_q_d;
      neg_r_q  <= neg_r_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // done is a one-cycle pulse; result and flags hold until the next answer,
  // so a core that samples late still reads the last completed transfer
  // busy covers the whole division so the core holds its transfer
  assign o_busy   = (state_q != ST_IDLE);
  assign o_done   = done_q;
  assign o_result = result_q;
  assign o_flags  = flags_q;

endmodule : muldiv_coprocessor
`default_nettype wire

// ==== core_model.sv ====
// Purpose: core-side partner issuing coprocessor transfers
// Assumes: strobes change on the falling edge of i_sys_clk
// Notes:   idle operand lines show inverted data, never a stale value
`timescale 1ns/1ns
`default_nettype none
module core_model
  import muldiv_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_done,
  input  wire logic [DATA_W-1:0] i_result,
  input  wire logic [3:0]        i_flags,
  output logic                   o_mode_wr,
  output logic                   o_operand,
  output logic                   o_preload,
  output logic      [DATA_W-1:0] o_dest,
  output logic      [DATA_W-1:0] o_src
);
  logic [DATA_W-1:0] res;
  logic [3:0]        flg;
  // =========================================
  // transfer tasks
  initial
  begin
    {o_mode_wr, o_operand, o_preload} = 3'h0;
    o_dest = 16'h0000;
    o_src = 16'h0000;
  end
  // kind 0 mode write, 1 preload, 2 operand transfer; one cycle each
  task automatic pulse(input int k, input logic [15:0] d, input logic [15:0] s);
    @(negedge i_sys_clk);
    o_dest = d;
    o_src = s;
    o_mode_wr = (k == 0);
    o_preload = (k == 1);
    o_operand = (k == 2);
    @(negedge i_sys_clk);
    {o_mode_wr, o_operand, o_preload} = 3'h0;
    o_dest = ~d;
    o_src = ~s;
  endtask : pulse
  // waits out a division stall; a zero divisor is never sent
  task automatic op(input logic [15:0] d, input logic [15:0] s);
    res = 'x;
    flg = 'x;
    pulse(2, d, s);
    repeat (40)
    begin
      if (i_done === 1'b1)
      begin
        res = i_result;
        flg = i_flags;
        return;
      end
      @(negedge i_sys_clk);
    end
  endtask : op
endmodule : core_model
`default_nettype wire

// ==== muldiv_sva.sv ====
// Purpose: timing and value checks on the coprocessor ports
// Assumes: mode word mirrored from accepted mode writes
// Notes:   bound to every coprocessor instance
`timescale 1ns/1ns
`default_nettype none
module muldiv_sva
  import muldiv_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_nrst,
  input wire logic              i_mode_write_transfer,
  input wire logic              i_operand_transfer,
  input wire logic              i_preload_transfer,
  input wire logic [DATA_W-1:0] i_dest_operand,
  input wire logic [DATA_W-1:0] i_src_operand,
  input wire logic              o_busy,
  input wire logic              o_done,
  input wire logic [DATA_W-1:0] o_result,
  input wire logic [3:0]        o_flags
);
  logic [MODE_W-1:0] mode_q;
  logic [DATA_W-1:0] prod_hi;
  logic [DATA_W-1:0] prod_lo;
  logic              take;
  // =========================================
  // helpers: unsigned product, accepted operand transfer
  assign {prod_hi, prod_lo} = {16'h0, i_dest_operand} * {16'h0, i_src_operand};
  assign take = i_operand_transfer && !o_busy && !i_mode_write_transfer && !i_preload_transfer;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      mode_q <= MODE_RESET;
    else if (i_mode_write_transfer && !o_busy)
      mode_q <= i_src_operand[6:0];
  end
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  sequence s_mul;
    take && mode_q[3:1] == 3'h2;
  endsequence
  sequence s_div;
    take && mode_q[3:1] == 3'h4;
  endsequence
  // =========================================
  // assertions
  AST_MAC_ONE_CYCLE: assert property (take && mode_q[3:2] == 2'h1 |=> o_done && !o_busy)
    else $error("multiply not answered next cycle");
  AST_MUL_FLAGS: assert property (s_mul |=> o_flags == FLAGS_CLEAR)
    else $error("multiply flags not clear");
  AST_MUL_LO: assert property (s_mul ##0 mode_q[6:4] == OUT_R0_LO |=> o_result == $past(prod_lo))
    else $error("multiply low half wrong");
  AST_MUL_HI: assert property (take && mode_q == 7'h14 |=> o_result == $past(prod_hi))
    else $error("multiply high half wrong");
  AST_UMAC_FLAGS: assert property (take && mode_q[3:0] == OP_MACU |=> o_flags == FLAGS_CLEAR)
    else $error("unsigned accumulate raised a flag");
  AST_DIV_LAT: assert property (s_div |-> ##[17:20] o_done)
    else $error("division latency out of range");
  AST_DIV_STALL: assert property (s_div |=> o_busy[*8])
    else $error("division did not stall");
  AST_MODE_QUIET: assert property ((i_mode_write_transfer || i_preload_transfer) && !o_busy |=> !o_done)
    else $error("mode write or preload answered");
endmodule : muldiv_sva
bind muldiv_coprocessor muldiv_sva u_sva (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .i_mode_write_transfer(i_mode_write_transfer), .i_operand_transfer(i_operand_transfer),
  .i_preload_transfer(i_preload_transfer), .i_dest_operand(i_dest_operand),
  .i_src_operand(i_src_operand), .o_busy(o_busy), .o_done(o_done), .o_result(o_result),
  .o_flags(o_flags));
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: directed transfer sequences against the coprocessor
// Assumes: 10 MHz clock, inputs change on the falling edge
// Notes:   mode 0x29 output is undefined and never compared
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import muldiv_pkg::*;
  logic        i_sys_clk;
  logic        i_nrst;
  logic        mode_wr;
  logic        operand;
  logic        preload;
  logic        busy;
  logic        done;
  logic [15:0] dest;
  logic [15:0] src;
  logic [15:0] result;
  logic [3:0]  flags;
  int          miscompares;
  int          n_checks;
  int          cycles;
  muldiv_coprocessor dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_mode_write_transfer(mode_wr), .i_operand_transfer(operand),
    .i_preload_transfer(preload), .i_dest_operand(dest), .i_src_operand(src),
    .o_busy(busy), .o_done(done), .o_result(result), .o_flags(flags));
  core_model core (.i_sys_clk(i_sys_clk), .i_done(done), .i_result(result),
    .i_flags(flags), .o_mode_wr(mode_wr), .o_operand(operand), .o_preload(preload),
    .o_dest(dest), .o_src(src));
  // =========================================
  // clock, hang guard and shared tasks
  initial
  begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // cut a hang short; the whole run needs far fewer cycles
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask : chk
  // upper source bits and destination are junk: only bits 6..0 count
  task automatic md(input logic [6:0] m);
    core.pulse(0, 16'hA5A5, {9'h1FF, m});
  endtask : md
  task automatic rd(input logic [15:0] d, input logic [15:0] s, input logic [15:0] e);
    core.op(d, s);
    chk("result", core.res, e);
  endtask : rd
  // =========================================
  // main sequence
  initial
  begin
    i_nrst = 1'b0;
    repeat (16) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    md(7'h04);
    rd(16'hFFFF, 16'hFFFF, 16'h0001);
    chk("flags", {12'h0, core.flg}, 16'h0000);
    md(7'h13);
    rd(16'h0000, 16'h0000, 16'hFFFE);
    md(7'h15);
    rd(16'hFFFF, 16'h0002, 16'hFFFF);
    md(7'h14);
    rd(16'hFFFF, 16'h0002, 16'h0001);
    md(7'h01);
    core.pulse(1, 16'h1234, 16'h5678);
    md(7'h13);
    rd(16'h0000, 16'h0000, 16'h0000);
    md(7'h03);
    rd(16'h0000, 16'h0000, 16'h5678);
    md(7'h0A);
    core.pulse(1, 16'h9ABC, 16'hDEF0);
    md(7'h33);
    rd(16'h0000, 16'h0000, 16'h9ABC);
    md(7'h00);
    md(7'h23);
    rd(16'h0000, 16'h0000, 16'h0000);
    md(7'h06);
    rd(16'h0003, 16'h0004, 16'h000C);
    rd(16'h0005, 16'h0006, 16'h002A);
    md(7'h02);
    core.pulse(1, 16'h7FFF, 16'hFFFF);
    md(7'h07);
    rd(16'h0001, 16'h0001, 16'h0000);
    chk("flags", {12'h0, core.flg}, 16'h0004);
    md(7'h02);
    core.pulse(1, 16'h0001, 16'h86A3);
    md(7'h08);
    rd(16'h0000, 16'h0007, 16'h37CE);
    chk("flags", {12'h0, core.flg}, 16'h0000);
    md(7'h23);
    rd(16'h0000, 16'h0000, 16'h0001);
    md(7'h02);
    core.pulse(1, 16'hFFFF, 16'hFF9C);
    md(7'h09);
    rd(16'h0000, 16'h0007, 16'hFFF2);
    md(7'h23);
    rd(16'h0000, 16'h0000, 16'hFFFE);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
